//--- logic/charger_ctl_pkg.sv
// Constants, field positions and carrier types for the charger control registers.
// Assumes a 200 MHz clock and a register port already decoded from the I2C engine.
package charger_ctl_pkg;
    localparam logic [7:0] FLAG_ADDR = 8'h04;
    localparam logic [7:0] PROT_EN_ADDR = 8'h05;
    localparam logic [7:0] SW_CTL_ADDR = 8'h06;
    localparam logic [7:0] PROT_EN_RST = 8'hFE;
    localparam logic [7:0] SW_CTL_RST = 8'h28;
    localparam logic [7:0] FLAG_RST = 8'h00;
    localparam int PE_OVP = 7;
    localparam int PE_IBUS = 6;
    localparam int PE_VBAT = 5;
    localparam int PE_IBAT = 4;
    localparam int PE_OUTV = 3;
    localparam int PE_TBUS = 2;
    localparam int PE_TBAT = 1;
    localparam int PE_PD = 0;
    localparam int SW_DROP_PROT = 7;
    localparam int SW_DROP_ALM = 6;
    localparam int SW_SHUNT = 5;
    localparam int SW_SWITCH = 4;
    localparam int SW_WDT_HI = 3;
    localparam int SW_WDT_LO = 2;
    localparam int SW_REV = 1;
    localparam int SW_SOFT_RST = 0;
    localparam int INT_DROP_ALM = 5;
    localparam int INT_DROP_PROT = 4;
    localparam logic [1:0] WDT_OFF = 2'h0;
    localparam logic [1:0] WDT_HALF = 2'h1;
    localparam logic [1:0] WDT_ONE = 2'h2;
    localparam logic [1:0] WDT_TWO = 2'h3;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned WDT_STEP_MS = 500;
    localparam int unsigned WDT_STEP_CYCLES = WDT_STEP_MS * 32'd1000000 / CLK_PERIOD_NS;
    localparam int unsigned DROP_GLITCH_NS = 10000;
    localparam logic [11:0] DROP_GLITCH_CYCLES = 12'((DROP_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef struct packed {
        logic drop_alarm;
        logic drop_protect;
        logic hw_fault;
        logic battery_hot;
        logic input_hot;
        logic input_uvlo;
        logic input_ov;
    } sense_t;

    typedef struct packed {
        logic input_overvoltage_guard_on;
        logic input_current_loop_on;
        logic cell_voltage_loop_on;
        logic charge_current_loop_on;
        logic output_voltage_loop_on;
        logic input_thermistor_guard_on;
        logic battery_thermistor_guard_on;
        logic input_pulldown_on;
        logic shunt_value_select;
        logic reverse_limit_select;
    } ctl_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

//--- logic/protection_switch_control_regs.sv
// Protection enable and switch control registers with host watchdog and switch gating.
// Assumes the I2C engine delivers one-cycle rd/wr strobes; comparator inputs are asynchronous.
`timescale 1ns/1ps

module protection_switch_control_regs #(
    parameter int unsigned WDT_STEP = charger_ctl_pkg::WDT_STEP_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic reset_pin_n,
    input wire charger_ctl_pkg::reg_req_t reg_req,
    input wire charger_ctl_pkg::sense_t sense,
    output logic [7:0] rdata,
    output charger_ctl_pkg::ctl_t ctl,
    output logic switch_closed,
    output logic drop_protection_flag,
    output logic drop_alarm_flag,
    output logic watchdog_irq
);
    import charger_ctl_pkg::*;

    logic [1:0] rst_s_q;
    logic rst_n;
    logic [2:0] pin_s_q, pin_s_d;
    logic pin_f_q, pin_f_d, pin_fall;
    sense_t s1_q, s2_q, s3_q, sf_q, sf_d;
    logic [7:0] prot_q, prot_d, sw_q, sw_d, rdata_q, rdata_d, flag_v;
    logic [31:0] wdt_cnt_q, wdt_cnt_d, wdt_limit;
    logic [11:0] glitch_q, glitch_d;
    logic drop_q, drop_d, alarm_q, alarm_d, switch_q, switch_d, irq_q, irq_d;
    logic access, soft_rst, wdt_on, wdt_expire, trip, fault_open, regs_reset, rd_flags;

    // Reset release through two flops so all logic leaves reset on one edge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_s_q <= 2'h0;
        end else begin
            rst_s_q <= {rst_s_q[0], 1'b1};
        end
    end
    assign rst_n = rst_s_q[1];

    // Pin and comparator synchronisers; a change counts once stages two and three agree
    always_comb begin
        pin_s_d = {pin_s_q[1:0], reset_pin_n};
        pin_f_d = (pin_s_q[1] == pin_s_q[2]) ? pin_s_q[2] : pin_f_q;
        pin_fall = pin_f_q & ~pin_s_q[1] & ~pin_s_q[2];
        sf_d = (s2_q & s3_q) | (sf_q & (s2_q | s3_q));
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_s_q <= 3'h7;
            pin_f_q <= 1'b1;
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            sf_q <= '0;
        end else begin
            pin_s_q <= pin_s_d;
            pin_f_q <= pin_f_d;
            s1_q <= sense;
            s2_q <= s1_q;
            s3_q <= s2_q;
            sf_q <= sf_d;
        end
    end

    // Watchdog, drop filter, protection decisions and register updates
    always_comb begin
        access = reg_req.rd | reg_req.wr;
        soft_rst = reg_req.wr && reg_req.addr == SW_CTL_ADDR && reg_req.wdata[SW_SOFT_RST];
        rd_flags = reg_req.rd && reg_req.addr == FLAG_ADDR;
        unique case (sw_q[SW_WDT_HI:SW_WDT_LO])
            WDT_OFF: wdt_limit = 32'h0;
            WDT_HALF: wdt_limit = WDT_STEP;
            WDT_ONE: wdt_limit = 32'(2 * WDT_STEP);
            WDT_TWO: wdt_limit = 32'(4 * WDT_STEP);
        endcase
        wdt_on = sw_q[SW_WDT_HI:SW_WDT_LO] != WDT_OFF;
        // A pin reset may shorten the limit, so it restarts the count; >= stops a count from running past it
        wdt_expire = wdt_on && !access && wdt_cnt_q >= wdt_limit - 32'h1;
        wdt_cnt_d = (!wdt_on || access || wdt_expire || pin_fall) ? 32'h0 : wdt_cnt_q + 32'h1;
        if (!sf_q.drop_protect) begin
            glitch_d = 12'h0;
        end else if (glitch_q == DROP_GLITCH_CYCLES) begin
            glitch_d = glitch_q;
        end else begin
            glitch_d = glitch_q + 12'h1;
        end
        trip = sw_q[SW_DROP_PROT] && glitch_q == DROP_GLITCH_CYCLES;
        fault_open = (sf_q.input_ov & prot_q[PE_OVP])
            | (sf_q.input_hot & prot_q[PE_TBUS])
            | (sf_q.battery_hot & prot_q[PE_TBAT])
            | sf_q.hw_fault | trip | wdt_expire;
        regs_reset = pin_fall | soft_rst | wdt_expire;
        prot_d = prot_q;
        sw_d = sw_q;
        if (reg_req.wr && reg_req.addr == PROT_EN_ADDR) begin
            prot_d = reg_req.wdata;
        end
        if (reg_req.wr && reg_req.addr == SW_CTL_ADDR) begin
            sw_d = {reg_req.wdata[7:1], 1'b0};
        end
        // Hardware clear beats a same-cycle host write: safety over software intent
        if (fault_open) begin
            sw_d[SW_SWITCH] = 1'b0;
        end
        if (regs_reset) begin
            prot_d = PROT_EN_RST;
            sw_d = SW_CTL_RST;
        end
        // Undervoltage holds the switch open but leaves the enable bit alone
        switch_d = sw_d[SW_SWITCH] & ~sf_q.input_uvlo;
        drop_d = trip | (drop_q & ~rd_flags & ~regs_reset);
        alarm_d = (sw_q[SW_DROP_ALM] & sf_q.drop_alarm) | (alarm_q & ~rd_flags & ~regs_reset);
        irq_d = wdt_expire;
        flag_v = FLAG_RST;
        flag_v[INT_DROP_ALM] = alarm_q;
        flag_v[INT_DROP_PROT] = drop_q;
        rdata_d = rdata_q;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                FLAG_ADDR: rdata_d = flag_v;
                PROT_EN_ADDR: rdata_d = prot_q;
                SW_CTL_ADDR: rdata_d = sw_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prot_q <= PROT_EN_RST;
            sw_q <= SW_CTL_RST;
            wdt_cnt_q <= 32'h0;
            glitch_q <= 12'h0;
            drop_q <= 1'b0;
            alarm_q <= 1'b0;
            switch_q <= 1'b0;
            irq_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            prot_q <= prot_d;
            sw_q <= sw_d;
            wdt_cnt_q <= wdt_cnt_d;
            glitch_q <= glitch_d;
            drop_q <= drop_d;
            alarm_q <= alarm_d;
            switch_q <= switch_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign switch_closed = switch_q;
    assign drop_protection_flag = drop_q;
    assign drop_alarm_flag = alarm_q;
    assign watchdog_irq = irq_q;
    assign ctl.input_overvoltage_guard_on = prot_q[PE_OVP];
    assign ctl.input_current_loop_on = prot_q[PE_IBUS];
    assign ctl.cell_voltage_loop_on = prot_q[PE_VBAT];
    assign ctl.charge_current_loop_on = prot_q[PE_IBAT];
    assign ctl.output_voltage_loop_on = prot_q[PE_OUTV];
    assign ctl.input_thermistor_guard_on = prot_q[PE_TBUS];
    assign ctl.battery_thermistor_guard_on = prot_q[PE_TBAT];
    assign ctl.input_pulldown_on = prot_q[PE_PD];
    assign ctl.shunt_value_select = sw_q[SW_SHUNT];
    assign ctl.reverse_limit_select = sw_q[SW_REV];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_ovp_write;
        reg_req.wr && reg_req.addr == PROT_EN_ADDR && !regs_reset
            |=> ctl.input_overvoltage_guard_on == $past(reg_req.wdata[PE_OVP]);
    endproperty
    a_ovp_write: assert property (p_ovp_write) else $error("overvoltage guard not written");

    property p_loops_write;
        reg_req.wr && reg_req.addr == PROT_EN_ADDR && !regs_reset
            |=> {ctl.input_current_loop_on, ctl.cell_voltage_loop_on, ctl.charge_current_loop_on,
                ctl.output_voltage_loop_on, ctl.input_thermistor_guard_on, ctl.battery_thermistor_guard_on}
                == $past(reg_req.wdata[PE_IBUS:PE_TBAT]);
    endproperty
    a_loops_write: assert property (p_loops_write) else $error("loop enables wrong");

    property p_pd_write;
        reg_req.wr && reg_req.addr == PROT_EN_ADDR && !regs_reset
            |=> ctl.input_pulldown_on == $past(reg_req.wdata[PE_PD]);
    endproperty
    a_pd_write: assert property (p_pd_write) else $error("pull-down enable wrong");

    property p_soft_reset;
        soft_rst |=> prot_q == PROT_EN_RST && sw_q == SW_CTL_RST && !drop_q ##1 !switch_closed;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("defaults not restored");

    property p_drop_trip;
        trip |=> !switch_closed && !sw_q[SW_SWITCH] && drop_protection_flag;
    endproperty
    a_drop_trip: assert property (p_drop_trip) else $error("drop trip missed");

    property p_alarm;
        sw_q[SW_DROP_ALM] && sf_q.drop_alarm |=> drop_alarm_flag;
    endproperty
    a_alarm: assert property (p_alarm) else $error("drop alarm not flagged");

    property p_wdt_restart;
        access |=> wdt_cnt_q == 32'h0;
    endproperty
    a_wdt_restart: assert property (p_wdt_restart) else $error("watchdog not restarted");

    property p_wdt_expire;
        watchdog_irq |-> !switch_closed && sw_q == SW_CTL_RST ##1 !watchdog_irq;
    endproperty
    a_wdt_expire: assert property (p_wdt_expire) else $error("watchdog expiry effects wrong");

    property p_switch_gate;
        switch_closed |-> sw_q[SW_SWITCH] && !$past(fault_open);
    endproperty
    a_switch_gate: assert property (p_switch_gate) else $error("switch closed without enable");

    // Antecedents leave out same-cycle reset causes, which override every field
    property p_shunt_write;
        reg_req.wr && reg_req.addr == SW_CTL_ADDR && !regs_reset
            |=> ctl.shunt_value_select == $past(reg_req.wdata[SW_SHUNT]);
    endproperty
    a_shunt_write: assert property (p_shunt_write) else $error("shunt select not written");

    property p_fault_clear;
        fault_open |=> !sw_q[SW_SWITCH] && !switch_closed;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault left switch enabled");

    property p_uvlo_hold;
        sf_q.input_uvlo && !fault_open && !regs_reset && !(reg_req.wr && reg_req.addr == SW_CTL_ADDR)
            |=> !switch_closed && sw_q[SW_SWITCH] == $past(sw_q[SW_SWITCH]);
    endproperty
    a_uvlo_hold: assert property (p_uvlo_hold) else $error("undervoltage handling wrong");

    property p_switch_close;
        sw_q[SW_SWITCH] && !sf_q.input_uvlo && !fault_open && !regs_reset
            && !(reg_req.wr && reg_req.addr == SW_CTL_ADDR) |=> switch_closed;
    endproperty
    a_switch_close: assert property (p_switch_close) else $error("switch failed to close");

    property p_pin_reset;
        pin_fall |=> prot_q == PROT_EN_RST && sw_q == SW_CTL_RST;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset left fields changed");

    property p_expire_reset;
        wdt_expire |=> prot_q == PROT_EN_RST && watchdog_irq;
    endproperty
    a_expire_reset: assert property (p_expire_reset) else $error("expiry did not restore defaults");

    property p_wdt_off;
        sw_q[SW_WDT_HI:SW_WDT_LO] == WDT_OFF |=> !watchdog_irq;
    endproperty
    a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog expired");

    property p_glitch_min;
        trip |-> $past(sf_q.drop_protect) && glitch_q == DROP_GLITCH_CYCLES;
    endproperty
    a_glitch_min: assert property (p_glitch_min) else $error("drop trip before filter time");

    property p_alarm_off;
        !drop_alarm_flag && !(sw_q[SW_DROP_ALM] && sf_q.drop_alarm) |=> !drop_alarm_flag;
    endproperty
    a_alarm_off: assert property (p_alarm_off) else $error("alarm flag set without cause");

    property p_flag_clear;
        rd_flags && !trip |=> !drop_protection_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("drop flag not cleared by read");

    property p_flag_read;
        rd_flags |=> rdata[INT_DROP_ALM] == $past(alarm_q) && rdata[INT_DROP_PROT] == $past(drop_q);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag read data wrong");

    // Main scenarios
    c_switch_close: cover property (!switch_closed ##1 switch_closed);
    c_wdt_irq: cover property (watchdog_irq);
    c_drop_flag: cover property (drop_protection_flag ##[1:4] rd_flags ##1 !drop_protection_flag);
    c_uvlo_hold: cover property (switch_closed ##1 !switch_closed && sw_q[SW_SWITCH]);
    c_soft_reset: cover property (soft_rst ##2 !switch_closed);
endmodule // protection_switch_control_regs

//--- dv/host_model.sv
// Host side model: single register reads and writes issued as one-cycle strobes.
// Assumes the register port samples on the rising edge and answers one cycle later.
`timescale 1ns/1ps
module host_model (
    input wire logic clock,
    input wire logic [7:0] rdata,
    output charger_ctl_pkg::reg_req_t reg_req
);
    import charger_ctl_pkg::*;
    initial reg_req = '0;
    // Callers keep accesses closer than the timeout and set the shunt bit to the fitted part
    task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] d);
        @(negedge clock);
        reg_req <= '{rd: rd, wr: !rd, addr: addr, wdata: wdata};
        @(negedge clock);
        // Released lines show inverted data so stale values are never mistaken for live ones
        reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
        d = rdata;
    endtask
endmodule // host_model

//--- dv/protection_switch_control_regs_tb.sv
// Self-checking bench for the protection and switch control registers.
// Assumes host_model drives the register port; watchdog step shortened to 50 cycles.
`timescale 1ns/1ps
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin errors++; \
    $display("Error t=%0t got %h exp %h", $time, act, exp); end end
module protection_switch_control_regs_tb;
    import charger_ctl_pkg::*;
    localparam int unsigned STEP = 50;
    typedef struct {logic [7:0] a; logic [7:0] v; logic [7:0] e;} row_t;
    row_t rows [7] = '{'{8'h05, 8'h00, 8'h00}, '{8'h05, 8'hA5, 8'hA5}, '{8'h05, 8'hFF, 8'hFF},
        '{8'h06, 8'h02, 8'h02}, '{8'h06, 8'hE0, 8'hE0}, '{8'h06, 8'h20, 8'h20}, '{8'h09, 8'h55, 8'h00}};
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic reset_pin_n = 1'b1;
    int irq_count = 0;
    sense_t sense = '0;
    reg_req_t reg_req;
    logic [7:0] rdata;
    logic [7:0] d;
    ctl_t ctl;
    logic switch_closed;
    logic drop_protection_flag;
    logic drop_alarm_flag;
    logic watchdog_irq;
    int errors = 0;
    int total_checks = 0;
    int n;
    always #2.5 clock = ~clock;
    always @(posedge clock) if (watchdog_irq === 1'b1) irq_count <= irq_count + 1;
    host_model i_host (.clock(clock), .rdata(rdata), .reg_req(reg_req));
    protection_switch_control_regs #(.WDT_STEP(STEP)) i_dut (.clock(clock), .arst_n(arst_n),
        .reset_pin_n(reset_pin_n), .reg_req(reg_req), .sense(sense), .rdata(rdata), .ctl(ctl),
        .switch_closed(switch_closed), .drop_protection_flag(drop_protection_flag),
        .drop_alarm_flag(drop_alarm_flag), .watchdog_irq(watchdog_irq));
    task automatic final_report();
        $display("errors=%0d total_checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        i_host.access(1'b0, a, v, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        i_host.access(1'b1, a, 8'h00, d);
        `CHK(d, e)
    endtask
    // Bounded wait on one of irq, drop flag, alarm flag, switch open, switch closed
    task automatic wait_for(input int sel, input int lim, output int cnt);
        logic [4:0] s;
        cnt = 0;
        s = '0;
        while (s[sel] !== 1'b1) begin
            @(negedge clock);
            cnt++;
            s = {switch_closed, !switch_closed, drop_alarm_flag, drop_protection_flag, watchdog_irq};
            if (s[sel] !== 1'b1 && cnt >= lim) begin
                errors++;
                $display("Error t=%0t wait %0h ran out after %0h cycles", $time, sel, cnt);
                final_report();
            end
        end
    endtask
    initial begin
        repeat (6) @(negedge clock);
        arst_n = 1'b1;
        repeat (3) @(negedge clock);
        `CHK(ctl, 10'h3FA)
        rd_chk(8'h05, PROT_EN_RST);
        rd_chk(8'h06, SW_CTL_RST);
        rd_chk(8'h04, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].v);
            rd_chk(rows[i].a, rows[i].e);
            if (rows[i].a == 8'h05) `CHK(ctl[9:2], rows[i].e)
            if (rows[i].a == 8'h06) `CHK(ctl[1:0], {rows[i].e[5], rows[i].e[1]})
        end
        wr(8'h05, 8'hFE);
        wr(8'h06, 8'h10);
        wait_for(4, 10, n);
        sense.input_ov = 1'b1;
        wait_for(3, 10, n);
        sense.input_ov = 1'b0;
        rd_chk(8'h06, 8'h00);
        wr(8'h05, 8'h7F);
        wr(8'h06, 8'h10);
        wait_for(4, 10, n);
        sense.input_ov = 1'b1;
        repeat (10) @(negedge clock);
        `CHK(switch_closed, 1'b1)
        sense.input_ov = 1'b0;
        sense.input_uvlo = 1'b1;
        wait_for(3, 10, n);
        rd_chk(8'h06, 8'h10);
        sense.input_uvlo = 1'b0;
        wait_for(4, 10, n);
        wr(8'h06, 8'h00);
        wait_for(3, 10, n);
        // Enabled thermistor guards and the hardware fault each open the switch and clear its enable
        for (int k = 0; k < 3; k++) begin
            wr(8'h06, 8'h10);
            wait_for(4, 10, n);
            sense = sense_t'(7'h04 << k);
            wait_for(3, 10, n);
            sense = '0;
            repeat (6) @(negedge clock);
            rd_chk(8'h06, 8'h00);
        end
        wr(8'h05, 8'h79);
        wr(8'h06, 8'h10);
        wait_for(4, 10, n);
        sense = sense_t'(7'h0C);
        repeat (10) @(negedge clock);
        `CHK(switch_closed, 1'b1)
        sense = '0;
        wr(8'h06, 8'h90);
        wait_for(4, 10, n);
        sense.drop_protect = 1'b1;
        repeat (1000) @(negedge clock);
        sense.drop_protect = 1'b0;
        repeat (10) @(negedge clock);
        `CHK(switch_closed, 1'b1)
        sense.drop_protect = 1'b1;
        wait_for(1, 2100, n);
        `CHK(n >= 2000, 1'b1)
        `CHK(switch_closed, 1'b0)
        sense.drop_protect = 1'b0;
        // The trip holds until the filtered comparator falls, so let it settle before reading
        repeat (6) @(negedge clock);
        rd_chk(8'h04, 8'h10);
        rd_chk(8'h04, 8'h00);
        `CHK(drop_protection_flag, 1'b0)
        wr(8'h06, 8'h40);
        sense.drop_alarm = 1'b1;
        wait_for(2, 10, n);
        sense.drop_alarm = 1'b0;
        repeat (6) @(negedge clock);
        rd_chk(8'h04, 8'h20);
        wr(8'h06, 8'h00);
        sense.drop_alarm = 1'b1;
        repeat (8) @(negedge clock);
        `CHK(drop_alarm_flag, 1'b0)
        sense.drop_alarm = 1'b0;
        repeat (6) @(negedge clock);
        wr(8'h05, 8'h00);
        wr(8'h06, 8'hC2);
        wr(8'h06, 8'h01);
        rd_chk(8'h05, PROT_EN_RST);
        rd_chk(8'h06, SW_CTL_RST);
        for (int i = 1; i < 4; i++) begin
            wr(8'h06, 8'h10 | 8'(i << 2));
            wait_for(0, STEP * 4 + 20, n);
            `CHK((n + 5 >= (STEP << (i - 1))) && (n <= (STEP << (i - 1)) + 5), 1'b1)
            repeat (2) @(negedge clock);
            `CHK(watchdog_irq, 1'b0)
            `CHK(switch_closed, 1'b0)
            rd_chk(8'h06, SW_CTL_RST);
        end
        wr(8'h06, 8'h14);
        n = irq_count;
        repeat (5) begin
            repeat (40) @(negedge clock);
            rd_chk(8'h05, PROT_EN_RST);
        end
        `CHK(irq_count, n)
        wr(8'h06, 8'h00);
        wr(8'h05, 8'h00);
        reset_pin_n = 1'b0;
        repeat (10) @(negedge clock);
        reset_pin_n = 1'b1;
        repeat (4) @(negedge clock);
        rd_chk(8'h05, PROT_EN_RST);
        rd_chk(8'h06, SW_CTL_RST);
        final_report();
    end
endmodule // protection_switch_control_regs_tb
